// ==== hw/modbus_config_holding_regs.sv ====
// configuration and identification holding registers behind a modbus slave
// assumes the frame decoder presents one checked request per cycle in req_in
`timescale 1ns/10ps

// How it works
// - baud_rate_code picks 4800, 9600, 19200, 38400, 57600 or 115200 baud for codes 0 to 5, default 2.
// - product_type_code is read only and writes leave it unchanged.
// - hardware_version is read only, major number in the high byte and minor in the low byte.
// - firmware_version is read only in the same major and minor byte format.
// - a nonzero timeout of 1 to 60 minutes drops the termination resistor and raises outputs_zero_out after that long with no traffic.
// - line_termination_ctrl connects the termination resistor at 1 and disconnects it at 0, default 0.
// - writing 1 to restore_defaults_cmd loads every holding register with its factory default.
// - restore_defaults_cmd clears itself when the restore is done, reading 1 only while it runs.
// - a low pressure alarm limit above the present pressure setpoint is rejected.
module modbus_config_holding_regs import modbus_cfg_pkg::*; #(
	parameter logic [15:0] PRODUCT_TYPE_CODE = 16'h0042, // arbitrary value
	parameter logic [15:0] HARDWARE_VERSION = 16'h0301, // arbitrary value
	parameter logic [15:0] FIRMWARE_VERSION = 16'h0405, // arbitrary value
	parameter logic [35:0] MINUTE_CYCLES = 36'(MINUTE_CYCLES_DEF)
) (
	input wire sys_clk_in,
	input wire reset_n_in,
	input reg_req_t req_in,
	input wire [15:0] pressure_setpoint_in,
	output reg_rsp_t rsp_out,
	output logic [7:0] slave_address_out,
	output logic [2:0] baud_rate_code_out,
	output logic [15:0] bit_cycles_out,
	output logic parity_enable_out,
	output logic parity_odd_out,
	output logic line_termination_resistor_out,
	output logic outputs_zero_out
);

	logic [15:0] slave_address;
	logic [15:0] baud_rate_code;
	logic [15:0] parity_mode;
	logic [15:0] comm_safety_timeout;
	logic [15:0] line_termination_ctrl;
	logic [15:0] restore_defaults_cmd;
	logic [15:0] pressure_alarm_low_limit;
	logic [35:0] tick_count;
	logic [5:0] minute_count;

	// request decode
	wire restoring = restore_defaults_cmd[0];
	wire station_hit = req_in.valid && (req_in.station == slave_address[7:0]);
	wire is_write = station_hit && req_in.write;
	wire [15:0] a = req_in.addr;
	wire [15:0] d = req_in.data;
	wire addr_mapped = (a >= REG_SLAVE_ADDRESS) && (a <= REG_PRESSURE_ALARM_LOW_LIMIT);
	wire addr_read_only = (a == REG_PRODUCT_TYPE_CODE) || (a == REG_HARDWARE_VERSION) ||
		(a == REG_FIRMWARE_VERSION);

	// value checks per register
	wire ok_slave = (d >= SLAVE_ADDRESS_MIN) && (d <= SLAVE_ADDRESS_MAX);
	wire ok_baud = d <= BAUD_RATE_CODE_MAX;
	wire ok_parity = d <= PARITY_MODE_MAX;
	wire ok_timeout = d <= COMM_SAFETY_TIMEOUT_MAX;
	wire ok_flag = d <= FLAG_VALUE_MAX;
	wire ok_alarm = d <= pressure_setpoint_in;
	wire value_ok = (a == REG_SLAVE_ADDRESS) ? ok_slave :
		(a == REG_BAUD_RATE_CODE) ? ok_baud :
		(a == REG_PARITY_MODE) ? ok_parity :
		(a == REG_COMM_SAFETY_TIMEOUT) ? ok_timeout :
		(a == REG_LINE_TERMINATION_CTRL) ? ok_flag :
		(a == REG_RESTORE_DEFAULTS_CMD) ? ok_flag :
		(a == REG_PRESSURE_ALARM_LOW_LIMIT) ? ok_alarm : 1'b1;

	// a write in the restore cycle would be overwritten, so it is refused as busy
	wire [7:0] write_exc = !addr_mapped ? EXC_ILLEGAL_ADDRESS :
		addr_read_only ? EXC_ILLEGAL_ADDRESS :
		restoring ? EXC_BUSY :
		!value_ok ? EXC_ILLEGAL_VALUE : EXC_NONE;
	wire [7:0] read_exc = addr_mapped ? EXC_NONE : EXC_ILLEGAL_ADDRESS;
	wire [7:0] next_exc = req_in.write ? write_exc : read_exc;
	wire write_go = is_write && (write_exc == EXC_NONE);

	wire wr_slave = write_go && (a == REG_SLAVE_ADDRESS);
	wire wr_baud = write_go && (a == REG_BAUD_RATE_CODE);
	wire wr_parity = write_go && (a == REG_PARITY_MODE);
	wire wr_timeout = write_go && (a == REG_COMM_SAFETY_TIMEOUT);
	wire wr_term = write_go && (a == REG_LINE_TERMINATION_CTRL);
	wire wr_restore = write_go && (a == REG_RESTORE_DEFAULTS_CMD);
	wire wr_alarm = write_go && (a == REG_PRESSURE_ALARM_LOW_LIMIT);

	// read mux; the identity words are constants, so writes cannot move them
	wire [15:0] read_data = (a == REG_SLAVE_ADDRESS) ? slave_address :
		(a == REG_BAUD_RATE_CODE) ? baud_rate_code :
		(a == REG_PARITY_MODE) ? parity_mode :
		(a == REG_PRODUCT_TYPE_CODE) ? PRODUCT_TYPE_CODE :
		(a == REG_HARDWARE_VERSION) ? HARDWARE_VERSION :
		(a == REG_FIRMWARE_VERSION) ? FIRMWARE_VERSION :
		(a == REG_RESERVED_WORD) ? RESERVED_READ_VALUE :
		(a == REG_COMM_SAFETY_TIMEOUT) ? comm_safety_timeout :
		(a == REG_LINE_TERMINATION_CTRL) ? line_termination_ctrl :
		(a == REG_RESTORE_DEFAULTS_CMD) ? restore_defaults_cmd :
		(a == REG_PRESSURE_ALARM_LOW_LIMIT) ? pressure_alarm_low_limit : 16'h0000;

	reg_rsp_t next_rsp;
	assign next_rsp.valid = station_hit;
	assign next_rsp.exception = next_exc;
	assign next_rsp.data = (!req_in.write && next_exc == EXC_NONE) ? read_data : 16'h0000;

	// baud code to bit period
	wire [15:0] next_bit_cycles = (baud_rate_code[2:0] == BAUD_CODE_4800) ? BIT_CYCLES_4800 :
		(baud_rate_code[2:0] == BAUD_CODE_9600) ? BIT_CYCLES_9600 :
		(baud_rate_code[2:0] == BAUD_CODE_19200) ? BIT_CYCLES_19200 :
		(baud_rate_code[2:0] == BAUD_CODE_38400) ? BIT_CYCLES_38400 :
		(baud_rate_code[2:0] == BAUD_CODE_57600) ? BIT_CYCLES_57600 :
		BIT_CYCLES_115200;

	// safety timeout: any request addressed to us counts as traffic
	wire minute_tick = (tick_count == MINUTE_CYCLES - 36'h0_0000_0001);
	wire [5:0] next_minute = (minute_count == 6'h3F) ? minute_count : minute_count + 6'h01;
	wire timed_out = (comm_safety_timeout != 16'h0000) &&
		({10'h000, minute_count} >= comm_safety_timeout);

	// configuration words; the restore cycle loads all defaults at once
	config_word #(
		.RESET_VALUE(DEF_SLAVE_ADDRESS)
	) slave_address_word (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.restore_in(restoring),
		.load_in(wr_slave),
		.data_in(d),
		.value_out(slave_address)
	);

	config_word #(
		.RESET_VALUE(DEF_BAUD_RATE_CODE)
	) baud_rate_code_word (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.restore_in(restoring),
		.load_in(wr_baud),
		.data_in(d),
		.value_out(baud_rate_code)
	);

	config_word #(
		.RESET_VALUE(DEF_PARITY_MODE)
	) parity_mode_word (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.restore_in(restoring),
		.load_in(wr_parity),
		.data_in(d),
		.value_out(parity_mode)
	);

	config_word #(
		.RESET_VALUE(DEF_COMM_SAFETY_TIMEOUT)
	) comm_safety_timeout_word (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.restore_in(restoring),
		.load_in(wr_timeout),
		.data_in(d),
		.value_out(comm_safety_timeout)
	);

	config_word #(
		.RESET_VALUE(DEF_LINE_TERMINATION_CTRL)
	) line_termination_ctrl_word (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.restore_in(restoring),
		.load_in(wr_term),
		.data_in(d),
		.value_out(line_termination_ctrl)
	);

	// the restore clears its own command word, so it lasts exactly one cycle
	config_word #(
		.RESET_VALUE(DEF_RESTORE_DEFAULTS_CMD)
	) restore_defaults_cmd_word (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.restore_in(restoring),
		.load_in(wr_restore),
		.data_in(d),
		.value_out(restore_defaults_cmd)
	);

	config_word #(
		.RESET_VALUE(DEF_PRESSURE_ALARM_LOW_LIMIT)
	) pressure_alarm_low_limit_word (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.restore_in(restoring),
		.load_in(wr_alarm),
		.data_in(d),
		.value_out(pressure_alarm_low_limit)
	);

	// traffic watchdog, counted in whole minutes
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tick_count <= 36'h0_0000_0000;
		end else if (station_hit || minute_tick) begin
			tick_count <= 36'h0_0000_0000;
		end else begin
			tick_count <= tick_count + 36'h0_0000_0001;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			minute_count <= 6'h00;
		end else if (station_hit) begin
			minute_count <= 6'h00;
		end else if (minute_tick) begin
			minute_count <= next_minute;
		end
	end

	// outputs, all registered; the timeout forces line_termination_resistor_out low
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rsp_out <= '0;
		end else begin
			rsp_out <= next_rsp;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			slave_address_out <= DEF_SLAVE_ADDRESS[7:0];
		end else begin
			slave_address_out <= slave_address[7:0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			baud_rate_code_out <= DEF_BAUD_RATE_CODE[2:0];
		end else begin
			baud_rate_code_out <= baud_rate_code[2:0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			bit_cycles_out <= BIT_CYCLES_19200;
		end else begin
			bit_cycles_out <= next_bit_cycles;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			parity_enable_out <= 1'b1;
		end else begin
			parity_enable_out <= (parity_mode[1:0] != PARITY_NONE);
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			parity_odd_out <= 1'b0;
		end else begin
			parity_odd_out <= (parity_mode[1:0] == PARITY_ODD);
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			line_termination_resistor_out <= 1'b0;
		end else begin
			line_termination_resistor_out <= line_termination_ctrl[0] && !timed_out;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			outputs_zero_out <= 1'b0;
		end else begin
			outputs_zero_out <= timed_out;
		end
	end

endmodule : modbus_config_holding_regs

// one holding word: factory value at reset and on restore, else the written value
module config_word import modbus_cfg_pkg::*; #(
	parameter logic [15:0] RESET_VALUE = 16'h0000
) (
	input wire sys_clk_in,
	input wire reset_n_in,
	input wire restore_in,
	input wire load_in,
	input wire [15:0] data_in,
	output logic [15:0] value_out
);

	// restore outranks a load; loads in that cycle are refused busy upstream
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			value_out <= RESET_VALUE;
		end else if (restore_in) begin
			value_out <= RESET_VALUE;
		end else if (load_in) begin
			value_out <= data_in;
		end
	end

endmodule : config_word

// ==== hw/modbus_cfg_pkg.sv ====
// constants and carrier types for the configuration holding-register bank
// assumes a 100 MHz system clock and a frame decoder that hands over whole requests
package modbus_cfg_pkg;

	// holding register numbers as seen on the wire
	localparam logic [15:0] REG_SLAVE_ADDRESS = 16'h0001;
	localparam logic [15:0] REG_BAUD_RATE_CODE = 16'h0002;
	localparam logic [15:0] REG_PARITY_MODE = 16'h0003;
	localparam logic [15:0] REG_PRODUCT_TYPE_CODE = 16'h0004;
	localparam logic [15:0] REG_HARDWARE_VERSION = 16'h0005;
	localparam logic [15:0] REG_FIRMWARE_VERSION = 16'h0006;
	localparam logic [15:0] REG_RESERVED_WORD = 16'h0007;
	localparam logic [15:0] REG_COMM_SAFETY_TIMEOUT = 16'h0008;
	localparam logic [15:0] REG_LINE_TERMINATION_CTRL = 16'h0009;
	localparam logic [15:0] REG_RESTORE_DEFAULTS_CMD = 16'h000A;
	localparam logic [15:0] REG_PRESSURE_ALARM_LOW_LIMIT = 16'h000B;

	// factory defaults
	localparam logic [15:0] DEF_SLAVE_ADDRESS = 16'h0001;
	localparam logic [15:0] DEF_BAUD_RATE_CODE = 16'h0002;
	localparam logic [15:0] DEF_PARITY_MODE = 16'h0001;
	localparam logic [15:0] DEF_COMM_SAFETY_TIMEOUT = 16'h0000;
	localparam logic [15:0] DEF_LINE_TERMINATION_CTRL = 16'h0000;
	localparam logic [15:0] DEF_RESTORE_DEFAULTS_CMD = 16'h0000;
	localparam logic [15:0] DEF_PRESSURE_ALARM_LOW_LIMIT = 16'h0000;
	localparam logic [15:0] RESERVED_READ_VALUE = 16'h0000;

	// legal value limits
	localparam logic [15:0] SLAVE_ADDRESS_MIN = 16'h0001;
	localparam logic [15:0] SLAVE_ADDRESS_MAX = 16'h00F7;
	localparam logic [15:0] BAUD_RATE_CODE_MAX = 16'h0005;
	localparam logic [15:0] PARITY_MODE_MAX = 16'h0002;
	localparam logic [15:0] COMM_SAFETY_TIMEOUT_MAX = 16'h003C;
	localparam logic [15:0] FLAG_VALUE_MAX = 16'h0001;

	// codes of the baud and parity selectors
	localparam logic [2:0] BAUD_CODE_4800 = 3'h0;
	localparam logic [2:0] BAUD_CODE_9600 = 3'h1;
	localparam logic [2:0] BAUD_CODE_19200 = 3'h2;
	localparam logic [2:0] BAUD_CODE_38400 = 3'h3;
	localparam logic [2:0] BAUD_CODE_57600 = 3'h4;
	localparam logic [1:0] PARITY_NONE = 2'h0;
	localparam logic [1:0] PARITY_EVEN = 2'h1;
	localparam logic [1:0] PARITY_ODD = 2'h2;

	// baud rates in bit/s
	localparam logic [63:0] BAUD_4800 = 64'h0000_0000_0000_12C0;
	localparam logic [63:0] BAUD_9600 = 64'h0000_0000_0000_2580;
	localparam logic [63:0] BAUD_19200 = 64'h0000_0000_0000_4B00;
	localparam logic [63:0] BAUD_38400 = 64'h0000_0000_0000_9600;
	localparam logic [63:0] BAUD_57600 = 64'h0000_0000_0000_E100;
	localparam logic [63:0] BAUD_115200 = 64'h0000_0000_0001_C200;

	// timing
	localparam logic [63:0] CLK_HZ = 64'h0000_0000_05F5_E100;
	localparam logic [63:0] MINUTE_S = 64'h0000_0000_0000_003C;
	localparam logic [63:0] MINUTE_CYCLES_DEF = CLK_HZ * MINUTE_S;
	localparam logic [15:0] BIT_CYCLES_4800 = 16'(CLK_HZ / BAUD_4800);
	localparam logic [15:0] BIT_CYCLES_9600 = 16'(CLK_HZ / BAUD_9600);
	localparam logic [15:0] BIT_CYCLES_19200 = 16'(CLK_HZ / BAUD_19200);
	localparam logic [15:0] BIT_CYCLES_38400 = 16'(CLK_HZ / BAUD_38400);
	localparam logic [15:0] BIT_CYCLES_57600 = 16'(CLK_HZ / BAUD_57600);
	localparam logic [15:0] BIT_CYCLES_115200 = 16'(CLK_HZ / BAUD_115200);

	// exception codes returned instead of data
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
	localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
	localparam logic [7:0] EXC_BUSY = 8'h06;

	typedef struct packed {
		logic valid;
		logic [7:0] station;
		logic write;
		logic [15:0] addr;
		logic [15:0] data;
	} reg_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] exception;
		logic [15:0] data;
	} reg_rsp_t;

endpackage : modbus_cfg_pkg

// ==== test/modbus_master_model.sv ====
// modbus master stand-in that hands whole register requests to the bank
// assumes the bench calls xfer at a falling edge of sys_clk_in
`timescale 1ns/10ps
module modbus_master_model import modbus_cfg_pkg::*; (
	input wire sys_clk_in,
	output reg_req_t req_out,
	input reg_rsp_t rsp_in
);
	initial req_out = '0;
	task automatic xfer(input logic [7:0] st, input logic w, input logic [15:0] a,
		input logic [15:0] d, output logic got, output logic [7:0] exc, output logic [15:0] q);
		req_out = '{1'b1, st, w, a, d};
		@(negedge sys_clk_in);
		// the answer only stands until the next rising edge, so take it here
		got = rsp_in.valid;
		exc = rsp_in.exception;
		q = rsp_in.data;
		// released fields must not keep showing the old request
		req_out = '{1'b0, ~st, ~w, ~a, ~d};
		@(negedge sys_clk_in);
	endtask : xfer
	// a write followed straight away by a second request in the next cycle
	task automatic pair(input logic [7:0] st, input logic [15:0] a1, input logic [15:0] d,
		input logic w2, input logic [15:0] a2, output logic [7:0] exc1,
		output logic [7:0] exc2, output logic [15:0] q2);
		req_out = '{1'b1, st, 1'b1, a1, d};
		@(negedge sys_clk_in);
		exc1 = rsp_in.exception;
		req_out = '{1'b1, st, w2, a2, d};
		@(negedge sys_clk_in);
		exc2 = rsp_in.exception;
		q2 = rsp_in.data;
		req_out = '{1'b0, ~st, ~w2, ~a2, ~d};
		@(negedge sys_clk_in);
	endtask : pair
endmodule : modbus_master_model

// ==== test/modbus_config_holding_regs_chk.sv ====
// port-level assertions for the holding-register bank
// assumes it is bound to modbus_config_holding_regs with requests spaced apart
`timescale 1ns/10ps
module modbus_config_holding_regs_chk import modbus_cfg_pkg::*; #(
	parameter logic [35:0] MINUTE_CYCLES = 36'(MINUTE_CYCLES_DEF)
) (
	input wire sys_clk_in,
	input wire reset_n_in,
	input reg_req_t req_in,
	input wire [15:0] pressure_setpoint_in,
	input reg_rsp_t rsp_out,
	input logic [7:0] slave_address_out,
	input logic [2:0] baud_rate_code_out,
	input logic [15:0] bit_cycles_out,
	input logic parity_enable_out,
	input logic parity_odd_out,
	input logic line_termination_resistor_out,
	input logic outputs_zero_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	logic [35:0] quiet;
	wire taken = req_in.valid && req_in.station == slave_address_out;
	wire wr = taken && req_in.write;
	wire [2:0] bc = baud_rate_code_out;
	wire [15:0] bits_exp = bc == 3'h0 ? BIT_CYCLES_4800 : bc == 3'h1 ? BIT_CYCLES_9600 :
		bc == 3'h2 ? BIT_CYCLES_19200 : bc == 3'h3 ? BIT_CYCLES_38400 :
		bc == 3'h4 ? BIT_CYCLES_57600 : BIT_CYCLES_115200;
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) quiet <= '0;
		else quiet <= taken ? '0 : quiet + 1'b1;
	end
	sequence restore_req;
		wr && req_in.addr == REG_RESTORE_DEFAULTS_CMD && req_in.data == 16'h0001;
	endsequence
	sequence answered_ok;
		rsp_out.valid && rsp_out.exception == EXC_NONE;
	endsequence
	AST_ANSWER: assert property (rsp_out.valid == $past(taken)) else $error("answer mismatch");
	AST_BAUD: assert property (bc <= 3'h5 && bit_cycles_out == bits_exp) else $error("bit time");
	AST_PARITY: assert property (parity_odd_out |-> parity_enable_out) else $error("parity");
	AST_RO: assert property (wr && req_in.addr inside {[4:6]} |=> rsp_out.exception ==
		EXC_ILLEGAL_ADDRESS) else $error("read-only write accepted");
	AST_ZERO_TERM: assert property (outputs_zero_out |-> !line_termination_resistor_out)
		else $error("termination not zeroed");
	AST_ZERO_LATE: assert property ($rose(outputs_zero_out) |-> quiet >= MINUTE_CYCLES)
		else $error("timeout early");
	AST_ZERO_DROP: assert property (taken |-> ##2 !outputs_zero_out) else $error("no drop");
	AST_RESTORE: assert property (restore_req ##1 answered_ok |-> ##2 slave_address_out ==
		8'h01 && bc == 3'h2 && parity_enable_out && !parity_odd_out) else $error("restore");
	AST_ALARM: assert property (wr && req_in.addr == REG_PRESSURE_ALARM_LOW_LIMIT &&
		req_in.data > pressure_setpoint_in |=> rsp_out.exception == EXC_ILLEGAL_VALUE)
		else $error("alarm limit accepted");
	AST_BUSY: assert property (restore_req ##1 (wr && rsp_out.valid &&
		rsp_out.exception == EXC_NONE) |=> rsp_out.exception == EXC_BUSY)
		else $error("write during restore accepted");
endmodule : modbus_config_holding_regs_chk

// ==== test/modbus_config_holding_regs_tb.sv ====
// self-checking bench for the holding-register bank against a register model
// assumes the master model and checker files are compiled first
`timescale 1ns/10ps
module modbus_config_holding_regs_tb import modbus_cfg_pkg::*; ();
	localparam logic [35:0] MC = 36'h0_0000_0014;
	logic sys_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [15:0] pressure_setpoint_in = 16'h0000;
	reg_req_t req_in;
	reg_rsp_t rsp_out;
	logic [7:0] slave_address_out;
	logic [2:0] baud_rate_code_out;
	logic [15:0] bit_cycles_out;
	logic parity_enable_out, parity_odd_out, line_termination_resistor_out, outputs_zero_out;
	int bad_count = 0;
	int n_compared = 0;
	int k;
	logic [7:0] e1, e2;
	logic [15:0] q2;
	logic [15:0] m [0:11];
	initial forever #5 sys_clk_in = ~sys_clk_in;
	modbus_master_model mst (.sys_clk_in, .req_out(req_in), .rsp_in(rsp_out));
	modbus_config_holding_regs #(.MINUTE_CYCLES(MC)) dut (.sys_clk_in, .reset_n_in, .req_in,
		.pressure_setpoint_in, .rsp_out, .slave_address_out, .baud_rate_code_out,
		.bit_cycles_out, .parity_enable_out, .parity_odd_out,
		.line_termination_resistor_out, .outputs_zero_out);
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic op(input logic [7:0] st, input logic w, input logic [15:0] a, input logic [15:0] d);
		logic got;
		logic [7:0] exc, ee;
		logic [15:0] q, eq, lim;
		logic hit;
		hit = st == m[1][7:0];
		lim = a == 1 ? 16'h00F7 : a == 2 ? 16'h0005 : a == 3 ? 16'h0002 : a == 8 ? 16'h003C :
			a == 11 ? pressure_setpoint_in : a == 9 || a == 10 ? 16'h0001 : 16'hFFFF;
		ee = EXC_NONE;
		eq = 16'h0000;
		if (a == 0 || a > 11) ee = EXC_ILLEGAL_ADDRESS;
		else if (!w) eq = m[a];
		else if (a >= 4 && a <= 6) ee = EXC_ILLEGAL_ADDRESS;
		else if (d > lim || (a == 1 && d == 0)) ee = EXC_ILLEGAL_VALUE;
		if (hit && w && ee == EXC_NONE && a != 7) begin
			m[a] = a == 10 ? 16'h0000 : d;
			// restore brings back every writable default at once
			if (a == 10 && d == 1) m[1:11] = '{1, 2, 1, m[4], m[5], m[6], 0, 0, 0, 0, 0};
		end
		mst.xfer(st, w, a, d, got, exc, q);
		@(negedge sys_clk_in);
		chk("answer", {15'h0, hit}, {15'h0, got});
		if (hit) begin
			chk("exception", {8'h0, ee}, {8'h0, exc});
			chk("read data", eq, q);
		end
		chk("address out", m[1] & 16'h00FF, {8'h0, slave_address_out});
		chk("baud out", m[2], {13'h0, baud_rate_code_out});
		chk("parity", {14'h0, m[3] != 0, m[3] == 2}, {14'h0, parity_enable_out, parity_odd_out});
		chk("termination", m[9], {15'h0, line_termination_resistor_out});
	endtask : op
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results
	initial begin
		m = '{0, 1, 2, 1, 16'h0042, 16'h0301, 16'h0405, 0, 0, 0, 0, 0};
		void'($urandom(32'h2def));
		repeat (3) @(negedge sys_clk_in);
		chk("reset bit time", BIT_CYCLES_19200, bit_cycles_out);
		reset_n_in = 1'b1;
		for (int i = 0; i < 13; i++) op(8'h01, 1'b0, 16'(i), 16'h0000);
		op(8'h01, 1'b1, 16'h0009, 16'h0001);
		pressure_setpoint_in = 16'h0064;
		op(8'h01, 1'b1, 16'h000B, 16'h0065);
		op(8'h01, 1'b1, 16'h000B, 16'h0064);
		op(8'h01, 1'b1, 16'h000A, 16'h0001);
		op(8'h01, 1'b0, 16'h000A, 16'h0000);
		mst.pair(m[1][7:0], 16'h000A, 16'h0001, 1'b0, 16'h000A, e1, e2, q2);
		chk("restore answer", {8'h0, EXC_NONE}, {8'h0, e1});
		chk("restore in progress", 16'h0001, q2);
		mst.pair(m[1][7:0], 16'h000A, 16'h0001, 1'b1, 16'h0009, e1, e2, q2);
		chk("busy answer", {8'h0, EXC_BUSY}, {8'h0, e2});
		for (int i = 0; i < 300; i++) begin
			pressure_setpoint_in = 16'($urandom % 1024);
			op(m[1][7:0] + 8'(($urandom % 8) == 0), 1'($urandom), 16'($urandom % 13),
				16'($urandom % 256));
		end
		op(m[1][7:0], 1'b1, 16'h0009, 16'h0001);
		op(m[1][7:0], 1'b1, 16'h0008, 16'h0001);
		for (k = 0; k < 100 && outputs_zero_out !== 1'b1; k++) @(negedge sys_clk_in);
		chk("timeout window", 16'h0001, {15'h0, k >= MC - 2 && k < MC + 4});
		chk("zeroed termination", 16'h0000, {15'h0, line_termination_resistor_out});
		op(m[1][7:0], 1'b1, 16'h0008, 16'h0000);
		repeat (50) @(negedge sys_clk_in);
		chk("disabled timeout", 16'h0000, {15'h0, outputs_zero_out});
		results();
	end
endmodule : modbus_config_holding_regs_tb
bind modbus_config_holding_regs modbus_config_holding_regs_chk #(.MINUTE_CYCLES(MINUTE_CYCLES))
	chk_i (.sys_clk_in, .reset_n_in, .req_in, .pressure_setpoint_in, .rsp_out,
	.slave_address_out, .baud_rate_code_out, .bit_cycles_out, .parity_enable_out,
	.parity_odd_out, .line_termination_resistor_out, .outputs_zero_out);
